// ==== iwac_pkg.sv ====
// Operation
// [RQ1] wait-point 0: interrupt at eighth falling edge
// [RQ2] master, select 0: hold clock low after eight
// [RQ3] slave, select 0: stretch clock after eight
// [RQ4] wait-point 1: interrupt at ninth falling edge
// [RQ5] select 1: wait after nine clocks, both roles
// [RQ6] wait-point select ignored during address byte
// [RQ7] master always waits at ninth address clock
// [RQ8] matched slave waits at ninth, after acknowledge
// [RQ9] extension-code slave waits at eighth falling edge
// [RQ10] ack enable drives data low in ninth
// [RQ11] ack enable ignored on address, except extension
// [RQ12] both bits inert while unit disabled
// [RQ13] reset clears whole control register to zero
// [RQ14] ack disabled: data released in ninth clock
`default_nettype none
package iwac_pkg;
   localparam int unsigned IWAC_DATA_W     = 8;
   localparam int unsigned IWAC_ADDR_W     = 4;
   localparam int unsigned IWAC_FIFO_DEPTH = 2;
   localparam int unsigned IWAC_PTR_W      = 1;
   localparam int unsigned IWAC_CNT_W      = 2;

   // register offsets
   localparam logic [3:0] IWAC_CTRL_OFS = 4'h0;
   localparam logic [3:0] IWAC_STAT_OFS = 4'h1;
   localparam logic [3:0] IWAC_OWN_OFS  = 4'h2;
   localparam logic [3:0] IWAC_SHIFT_OFS = 4'h3;

   // control register bit positions
   localparam int unsigned IWAC_CTRL_EN_BIT   = 7;
   localparam int unsigned IWAC_CTRL_WREL_BIT = 5;
   localparam int unsigned IWAC_CTRL_WTS_BIT  = 3;
   localparam int unsigned IWAC_CTRL_ACKE_BIT = 2;

   // status register bit positions
   localparam int unsigned IWAC_STAT_WAIT_BIT  = 0;
   localparam int unsigned IWAC_STAT_ADDR_BIT  = 1;
   localparam int unsigned IWAC_STAT_EXT_BIT   = 2;
   localparam int unsigned IWAC_STAT_MATCH_BIT = 3;
   localparam int unsigned IWAC_STAT_RXV_BIT   = 4;

   localparam logic [7:0] IWAC_CTRL_RST = 8'h00;
   localparam logic [6:0] IWAC_OWN_RST  = 7'h00;
   localparam logic [3:0] IWAC_EXT_HI   = 4'h0;

   // bit positions within a byte frame
   localparam logic [3:0] IWAC_BIT_LAST_DATA = 4'h8;
   localparam logic [3:0] IWAC_BIT_ACK       = 4'h9;

   // master clock half period
   localparam int unsigned IWAC_SYS_CLK_NS   = 4;
   localparam int unsigned IWAC_SCL_HALF_NS  = 2500;
   localparam int unsigned IWAC_SCL_HALF_CYC =
      (IWAC_SCL_HALF_NS + IWAC_SYS_CLK_NS - 1) / IWAC_SYS_CLK_NS;
   localparam int unsigned IWAC_HALF_W = 10;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_DATA = 4'b0100,
      ST_SKIP = 4'b1000
   } iwac_state_t;
endpackage
`default_nettype wire

// ==== iwac_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module iwac_fifo
   import iwac_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   clk_en,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [IWAC_DATA_W-1:0] in_data,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic [IWAC_DATA_W-1:0]      out_data
);
   logic [IWAC_DATA_W-1:0] mem_q [IWAC_FIFO_DEPTH];
   logic [IWAC_PTR_W-1:0]  wr_ptr_q;
   logic [IWAC_PTR_W-1:0]  rd_ptr_q;
   logic [IWAC_CNT_W-1:0]  cnt_q;
   logic                   push;
   logic                   pop;

   assign in_ready  = (cnt_q != IWAC_CNT_W'(IWAC_FIFO_DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_q[rd_ptr_q];

   genvar g;
   generate
      for (g = 0; g < IWAC_FIFO_DEPTH; g++) begin : g_entry
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               mem_q[g] <= '0;
            end else if (clk_en && push && wr_ptr_q == IWAC_PTR_W'(g)) begin
               mem_q[g] <= in_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end else if (clk_en) begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== iwac_ctrl.sv ====
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iwac_ctrl
   import iwac_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   clk_en,
   input  wire logic [IWAC_ADDR_W-1:0] reg_addr,
   input  wire logic [IWAC_DATA_W-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [IWAC_DATA_W-1:0]      reg_rdata,
   input  wire logic                   master_mode,
   input  wire logic                   serial_clock_line_i,
   output logic                        serial_clock_line_o,
   output logic                        serial_clock_line_oe,
   input  wire logic                   serial_data_line_i,
   output logic                        serial_data_line_o,
   output logic                        serial_data_line_oe,
   output logic [IWAC_DATA_W-1:0]      rx_data,
   output logic                        rx_valid,
   input  wire logic                   rx_ready,
   output logic                        intr_req
);
   function automatic logic iwac_sel(input logic [IWAC_ADDR_W-1:0] a,
                                     input logic [3:0] ofs);
      return a == ofs;
   endfunction

   iwac_state_t            st_q;
   logic                   bus_unit_enable_q;
   logic                   wait_point_select_q;
   logic                   ack_drive_enable_q;
   logic [6:0]             own_addr_q;
   logic                   ext_code_rx_flag_q;
   logic                   addr_hit_q;
   logic                   wait_q;
   logic                   ack_q;
   logic                   intr_q;
   logic [3:0]             bit_cnt_q;
   logic [7:0]             shift_q;
   logic                   mclk_low_q;
   logic [IWAC_HALF_W-1:0] half_cnt_q;
   logic [IWAC_DATA_W-1:0] rdata_q;
   logic                   scl_s1, scl_s2, scl_s3;
   logic                   sda_s1, sda_s2, sda_s3;
   logic                   scl_fall, scl_rise, start_ev, stop_ev;
   logic                   fall_8, fall_9;
   logic                   byte_ext, byte_match;
   logic                   wait_set, wait_rel;
   logic                   push_valid, push_ready;
   logic                   master_act;

   // two-stage synchronisers, third stage only for edge finding
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
      end else if (clk_en) begin
         scl_s1 <= serial_clock_line_i;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= serial_data_line_i;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
      end
   end

   assign scl_fall = scl_s3 & ~scl_s2;
   assign scl_rise = ~scl_s3 & scl_s2;
   assign start_ev = sda_s3 & ~sda_s2 & scl_s2;
   assign stop_ev  = ~sda_s3 & sda_s2 & scl_s2;
   assign fall_8   = scl_fall && bit_cnt_q == IWAC_BIT_LAST_DATA;
   assign fall_9   = scl_fall && bit_cnt_q == IWAC_BIT_ACK;
   assign byte_ext   = (shift_q[7:4] == IWAC_EXT_HI);
   assign byte_match = (shift_q[7:1] == own_addr_q);
   assign master_act = bus_unit_enable_q && master_mode
                       && (st_q == ST_ADDR || st_q == ST_DATA);

   // software port: control, own address, read data one cycle later
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_unit_enable_q   <= IWAC_CTRL_RST[IWAC_CTRL_EN_BIT]; // see [RQ13]
         wait_point_select_q <= IWAC_CTRL_RST[IWAC_CTRL_WTS_BIT];
         ack_drive_enable_q  <= IWAC_CTRL_RST[IWAC_CTRL_ACKE_BIT];
         own_addr_q          <= IWAC_OWN_RST;
      end else if (clk_en && reg_wr) begin
         if (iwac_sel(reg_addr, IWAC_CTRL_OFS)) begin
            // only software writes change these bits, see [RQ12]
            bus_unit_enable_q   <= reg_wdata[IWAC_CTRL_EN_BIT];
            wait_point_select_q <= reg_wdata[IWAC_CTRL_WTS_BIT];
            ack_drive_enable_q  <= reg_wdata[IWAC_CTRL_ACKE_BIT];
         end
         if (iwac_sel(reg_addr, IWAC_OWN_OFS)) begin
            own_addr_q <= reg_wdata[6:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (clk_en) begin
         rdata_q <= '0;
         if (reg_rd) begin
            if (iwac_sel(reg_addr, IWAC_CTRL_OFS)) begin
               rdata_q[IWAC_CTRL_EN_BIT]   <= bus_unit_enable_q;
               rdata_q[IWAC_CTRL_WTS_BIT]  <= wait_point_select_q;
               rdata_q[IWAC_CTRL_ACKE_BIT] <= ack_drive_enable_q;
            end else if (iwac_sel(reg_addr, IWAC_STAT_OFS)) begin
               rdata_q[IWAC_STAT_WAIT_BIT]  <= wait_q;
               rdata_q[IWAC_STAT_ADDR_BIT]  <= (st_q == ST_ADDR);
               rdata_q[IWAC_STAT_EXT_BIT]   <= ext_code_rx_flag_q;
               rdata_q[IWAC_STAT_MATCH_BIT] <= addr_hit_q;
               rdata_q[IWAC_STAT_RXV_BIT]   <= rx_valid;
            end else if (iwac_sel(reg_addr, IWAC_OWN_OFS)) begin
               rdata_q[6:0] <= own_addr_q;
            end else if (iwac_sel(reg_addr, IWAC_SHIFT_OFS)) begin
               rdata_q <= shift_q;
            end
         end
      end
   end

   // byte framing: count rising edges, sample data on them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bit_cnt_q <= '0;
         shift_q   <= '0;
      end else if (clk_en) begin
         if (!bus_unit_enable_q || start_ev || stop_ev) begin
            bit_cnt_q <= '0;
         end else if (scl_rise && st_q != ST_IDLE) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q < IWAC_BIT_LAST_DATA) begin
               shift_q <= {shift_q[6:0], sda_s2};
            end
         end else if (fall_9) begin
            bit_cnt_q <= '0;
         end
      end
   end

   // frame state; a disabled unit sits idle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q               <= ST_IDLE;
         addr_hit_q         <= 1'b0;
         ext_code_rx_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (!bus_unit_enable_q || stop_ev) begin
            st_q               <= ST_IDLE;
            addr_hit_q         <= 1'b0;
            ext_code_rx_flag_q <= 1'b0;
         end else if (start_ev) begin
            st_q               <= ST_ADDR;
            addr_hit_q         <= 1'b0;
            ext_code_rx_flag_q <= 1'b0;
         end else begin
            unique case (st_q)
               ST_ADDR: begin
                  if (fall_8 && !master_mode) begin
                     addr_hit_q         <= byte_match;
                     ext_code_rx_flag_q <= byte_ext && !byte_match;
                  end
                  if (fall_9) begin
                     st_q <= (master_mode || addr_hit_q || ext_code_rx_flag_q)
                             ? ST_DATA : ST_SKIP;
                  end
               end
               ST_IDLE, ST_DATA, ST_SKIP: begin
                  st_q <= st_q;
               end
            endcase
         end
      end
   end

   // wait points; the select bit only counts once past the address byte
   always_comb begin
      wait_set = 1'b0;
      if (bus_unit_enable_q) begin
         unique case (st_q)
            ST_ADDR: begin
               // see [RQ6] [RQ7] [RQ8]
               wait_set = fall_9 && (master_mode || addr_hit_q);
               if (fall_8 && !master_mode && byte_ext && !byte_match) begin
                  wait_set = 1'b1; // see [RQ9]
               end
            end
            ST_DATA: begin
               // see [RQ1] [RQ2] [RQ3] [RQ4] [RQ5]
               wait_set = wait_point_select_q ? fall_9 : fall_8;
            end
            ST_IDLE, ST_SKIP: begin
               wait_set = 1'b0;
            end
         endcase
      end
   end

   // release only with room for the next byte, so a stalled reader loses nothing
   assign wait_rel = clk_en && reg_wr && iwac_sel(reg_addr, IWAC_CTRL_OFS)
                     && reg_wdata[IWAC_CTRL_WREL_BIT] && push_ready;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wait_q <= 1'b0;
         intr_q <= 1'b0;
      end else if (clk_en) begin
         intr_q <= wait_set; // see [RQ1] [RQ4]
         if (!bus_unit_enable_q || stop_ev) begin
            wait_q <= 1'b0; // see [RQ12]
         end else if (wait_set) begin
            wait_q <= 1'b1; // set beats a release in the same cycle
         end else if (wait_rel) begin
            wait_q <= 1'b0;
         end
      end
   end

   // acknowledge for the ninth clock is chosen at the eighth falling edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else if (clk_en) begin
         if (!bus_unit_enable_q || fall_9 || stop_ev || start_ev) begin
            ack_q <= 1'b0; // see [RQ12] [RQ14]
         end else if (fall_8 && !master_mode && st_q == ST_ADDR) begin
            // address ack is automatic; the enable bit only counts for
            // extension codes, see [RQ11] [RQ8]
            ack_q <= byte_match || (byte_ext && ack_drive_enable_q);
         end else if (fall_8 && st_q == ST_DATA) begin
            ack_q <= ack_drive_enable_q; // see [RQ10] [RQ14]
         end
      end
   end

   // master clock: half-period timer, stalls while a slave stretches
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mclk_low_q <= 1'b0;
         half_cnt_q <= '0;
      end else if (clk_en) begin
         if (!master_act) begin
            mclk_low_q <= 1'b0;
            half_cnt_q <= '0;
         end else if (wait_q || wait_set) begin
            mclk_low_q <= 1'b1; // see [RQ2] [RQ5]
            half_cnt_q <= '0;
         end else if (mclk_low_q || scl_s2) begin
            if (half_cnt_q == IWAC_HALF_W'(IWAC_SCL_HALF_CYC - 1)) begin
               half_cnt_q <= '0;
               mclk_low_q <= ~mclk_low_q;
            end else begin
               half_cnt_q <= half_cnt_q + 1'b1;
            end
         end
      end
   end

   // open-drain pins: outputs fixed low, enables pull the line
   assign serial_clock_line_o  = 1'b0;
   assign serial_clock_line_oe = wait_q || (master_act && mclk_low_q); // see [RQ2] [RQ3]
   assign serial_data_line_o   = 1'b0;
   assign serial_data_line_oe  = ack_q; // see [RQ10]
   assign reg_rdata            = rdata_q;
   assign intr_req             = intr_q;

   assign push_valid = clk_en && bus_unit_enable_q && fall_8 && st_q == ST_DATA;

   iwac_fifo u_rx_buf (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (shift_q),
      .out_valid (rx_valid),
      .out_ready (rx_ready && clk_en),
      .out_data  (rx_data)
   );

   a_wait_eighth_data: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ1]
      (clk_en && bus_unit_enable_q && st_q == ST_DATA && fall_8 && !wait_point_select_q
       && !stop_ev) |=> (wait_q && serial_clock_line_oe))
      else $error("no wait at eighth clock with select low");

   a_wait_ninth_data: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ5]
      (clk_en && bus_unit_enable_q && st_q == ST_DATA && fall_9 && wait_point_select_q
       && !stop_ev) |=> (wait_q && serial_clock_line_oe))
      else $error("no wait at ninth clock with select high");

   a_no_early_wait: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ4]
      (clk_en && st_q == ST_DATA && fall_8 && wait_point_select_q && !wait_q)
      |=> (!wait_q && !intr_req))
      else $error("wait at eighth clock with select high");

   a_intr_with_wait: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ1]
      $rose(wait_q) |-> intr_req)
      else $error("wait entered without interrupt request");

   a_master_addr_wait: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ7]
      (clk_en && bus_unit_enable_q && master_mode && st_q == ST_ADDR && fall_9
       && !stop_ev && !start_ev) |=> (wait_q && st_q == ST_DATA))
      else $error("master missed ninth address wait");

   a_ext_code_wait: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ9]
      (clk_en && bus_unit_enable_q && !master_mode && st_q == ST_ADDR && fall_8
       && byte_ext && !byte_match && !stop_ev && !start_ev)
      |=> (wait_q && ext_code_rx_flag_q))
      else $error("extension code wait missing at eighth clock");

   a_ack_drive_ninth: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ10]
      (clk_en && bus_unit_enable_q && st_q == ST_DATA && fall_8 && ack_drive_enable_q
       && !stop_ev && !start_ev) |=> serial_data_line_oe [*2])
      else $error("acknowledge not driven in ninth clock");

   a_nack_release: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ14]
      (clk_en && st_q == ST_DATA && fall_8 && !ack_drive_enable_q)
      |=> !serial_data_line_oe)
      else $error("data line driven with acknowledge disabled");

   a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ12]
      (clk_en && !bus_unit_enable_q) |=> (!serial_clock_line_oe && !serial_data_line_oe))
      else $error("pins driven while unit disabled");

   a_reset_clears: assert property (@(posedge sys_clk) // see [RQ13]
      rst |=> (!bus_unit_enable_q && !wait_point_select_q && !ack_drive_enable_q))
      else $error("control register not cleared by reset");
endmodule
`default_nettype wire

// ==== iwac_bus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module iwac_bus_master_model (
   input  wire logic scl_wire,
   input  wire logic sda_wire,
   output var  logic scl_pull,
   output var  logic sda_pull
);
   int   clk_no;
   logic ack_seen;
   logic hang;

   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      clk_no   = 0;
      ack_seen = 1'b1;
      hang     = 1'b0;
   end

   // a pulse only counts once the line is really high, so a slave stretch holds us here
   task automatic clock_high();
      int n;
      n = 0;
      scl_pull = 1'b0;
      while (scl_wire !== 1'b1 && n < 20000) begin
         #1;
         n++;
      end
      if (n >= 20000) hang = 1'b1;
      clk_no++;
      #8;
   endtask

   task automatic start_cond();
      clk_no   = 0;
      sda_pull = 1'b1;
      #12;
      scl_pull = 1'b1;
      #12;
   endtask

   // data changes only mid low phase, well away from either clock edge
   task automatic send_bit(input logic b);
      sda_pull = ~b;
      #12;
      clock_high();
      ack_seen = sda_wire;
      scl_pull = 1'b1;
      #12;
   endtask

   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
      send_bit(1'b1);
   endtask

   // hand the bus to a clocking device; data goes first so the clock rise is no stop
   task automatic let_go();
      sda_pull = 1'b0;
      #12;
      scl_pull = 1'b0;
   endtask

   task automatic stop_cond();
      sda_pull = 1'b1;
      #12;
      clock_high();
      sda_pull = 1'b0;
      #12;
   endtask
endmodule
`default_nettype wire

// ==== tb_i2c_wait_ack_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_wait_ack_control;
   import iwac_pkg::*;
   logic                   sys_clk, rst, clk_en, reg_wr, reg_rd, master_mode, rx_ready;
   logic [IWAC_ADDR_W-1:0] reg_addr;
   logic [IWAC_DATA_W-1:0] reg_wdata, reg_rdata, rx_data, rd_val;
   logic                   serial_clock_line_o, serial_clock_line_oe, serial_data_line_o;
   logic                   serial_data_line_oe, rx_valid, intr_req, m_scl, m_sda;
   wire                    scl_wire;
   wire                    sda_wire;
   int                     err_total, tests_run, intr_cnt, drive_cnt, scl_rises;

   // both lines are open drain with pull-ups
   assign scl_wire = ~(serial_clock_line_oe | m_scl);
   assign sda_wire = ~(serial_data_line_oe | m_sda);

   iwac_ctrl uut (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .master_mode, .serial_clock_line_i(scl_wire), .serial_clock_line_o, .serial_clock_line_oe,
      .serial_data_line_i(sda_wire), .serial_data_line_o, .serial_data_line_oe, .rx_data,
      .rx_valid, .rx_ready, .intr_req);
   iwac_bus_master_model m (.scl_wire, .sda_wire, .scl_pull(m_scl), .sda_pull(m_sda));

   always #2 sys_clk = ~sys_clk;
   always @(posedge scl_wire) scl_rises++;
   always @(posedge sys_clk) begin
      if (intr_req === 1'b1) intr_cnt++;
      if (serial_clock_line_oe === 1'b1 || serial_data_line_oe === 1'b1) drive_cnt++;
   end

   task automatic wrap_up();
      $display("mismatches %0d, checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("MISMATCH t=%0t %s", $time, what);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask

   task automatic reg_check(input logic [3:0] a, input logic [7:0] d, input string what);
      reg_read(a);
      chk(rd_val === d, what);
   endtask

   task automatic wait_intr(input int at);
      int n;
      n = 0;
      while (intr_req !== 1'b1 && n < 3000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= 3000) begin
         chk(1'b0, "no interrupt");
         wrap_up();
      end
      chk(m.clk_no == at, "interrupt at wrong clock");
      chk(serial_clock_line_oe === 1'b1, "clock line not held");
      // longer than the master's low phase, so a stretch must be visible on the wire
      repeat (20) @(posedge sys_clk);
      chk(scl_wire === 1'b0 && serial_clock_line_oe === 1'b1, "stretch not kept");
   endtask

   // the unit clocks the bus itself, so count rises on the wire instead of model clocks
   task automatic mst_wait(input int rises);
      int n;
      n = 0;
      while (intr_req !== 1'b1 && n < 15000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n >= 15000) begin
         chk(1'b0, "no master interrupt");
         wrap_up();
      end
      chk(scl_rises == rises, "master wait at wrong clock");
      chk(serial_clock_line_oe === 1'b1, "master clock line not held");
      // longer than a half period, so a running clock would show another rise
      repeat (700) @(posedge sys_clk);
      #1;
      chk(scl_wire === 1'b0 && scl_rises == rises, "master clock not kept low");
   endtask

   task automatic release_wait(input logic [7:0] ctl);
      reg_write(IWAC_CTRL_OFS, ctl | 8'h20);
      @(posedge sys_clk);
      #1;
      chk(serial_clock_line_oe === 1'b0, "wait not released");
   endtask

   task automatic xfer(input logic [7:0] b, input logic ack, input int at, input logic [7:0] ctl);
      fork
         m.send_byte(b);
         begin
            wait_intr(at);
            release_wait(ctl);
         end
      join
      chk(m.ack_seen === ack, "acknowledge level");
   endtask

   task automatic pop(input logic [7:0] d);
      chk(rx_valid === 1'b1 && rx_data === d, "buffer head");
      @(posedge sys_clk);
      rx_ready <= 1'b1;
      @(posedge sys_clk);
      rx_ready <= 1'b0;
      #1;
   endtask

   task automatic frame_end();
      m.stop_cond();
      repeat (10) @(posedge sys_clk);
      #1;
      chk(m.hang === 1'b0 && serial_clock_line_oe === 1'b0 && serial_data_line_oe === 1'b0
          && serial_clock_line_o === 1'b0 && serial_data_line_o === 1'b0,
          "bus not idle after stop");
   endtask

   task automatic t_regs();
      reg_check(IWAC_CTRL_OFS, 8'h00, "control reset value");
      reg_check(IWAC_STAT_OFS, 8'h00, "status reset value");
      reg_check(IWAC_OWN_OFS, 8'h00, "own address reset value");
      reg_write(4'hF, 8'hFF);
      reg_check(4'hF, 8'h00, "unmapped index");
      reg_write(IWAC_STAT_OFS, 8'hFF);
      reg_check(IWAC_STAT_OFS, 8'h00, "status written");
      reg_write(IWAC_CTRL_OFS, 8'h0C);
      reg_check(IWAC_CTRL_OFS, 8'h0C, "control bits not set");
      reg_write(IWAC_CTRL_OFS, 8'h00);
      reg_check(IWAC_CTRL_OFS, 8'h00, "control bits not cleared");
      // a frozen clock enable must swallow the write
      clk_en <= 1'b0;
      reg_write(IWAC_CTRL_OFS, 8'h0C);
      clk_en <= 1'b1;
      reg_check(IWAC_CTRL_OFS, 8'h00, "write taken with clock enable low");
   endtask

   task automatic t_off();
      reg_write(IWAC_OWN_OFS, 8'h55);
      reg_write(IWAC_CTRL_OFS, 8'h0C);
      intr_cnt  = 0;
      drive_cnt = 0;
      m.start_cond();
      m.send_byte(8'hAA);
      chk(m.ack_seen === 1'b1, "disabled unit acknowledged");
      chk(intr_cnt == 0 && drive_cnt == 0, "disabled unit drove the bus");
      frame_end();
   endtask

   task automatic t_sel0();
      reg_write(IWAC_CTRL_OFS, 8'h80);
      m.start_cond();
      xfer(8'hAA, 1'b0, 9, 8'h80);
      xfer(8'hA5, 1'b1, 17, 8'h80);
      fork
         m.send_byte(8'h3C);
         begin
            wait_intr(26);
            reg_write(IWAC_CTRL_OFS, 8'hA0);
            reg_read(IWAC_STAT_OFS);
            chk(rd_val[IWAC_STAT_WAIT_BIT] === 1'b1, "release taken while buffer full");
            pop(8'hA5);
            release_wait(8'h80);
         end
      join
      chk(m.ack_seen === 1'b1, "third byte acknowledged");
      pop(8'h3C);
      chk(rx_valid === 1'b0, "buffer not empty");
      frame_end();
   endtask

   task automatic t_sel1();
      reg_write(IWAC_CTRL_OFS, 8'h8C);
      m.start_cond();
      xfer(8'hAA, 1'b0, 9, 8'h8C);
      xfer(8'h5A, 1'b0, 18, 8'h8C);
      pop(8'h5A);
      frame_end();
   endtask

   task automatic t_ext();
      reg_write(IWAC_CTRL_OFS, 8'h84);
      m.start_cond();
      xfer(8'h08, 1'b0, 8, 8'h84);
      reg_read(IWAC_STAT_OFS);
      chk(rd_val[IWAC_STAT_EXT_BIT] === 1'b1, "extension flag");
      frame_end();
   endtask

   // master role: the unit clocks a released bus, so every sampled bit reads high
   task automatic t_mst();
      @(posedge sys_clk);
      master_mode <= 1'b1;
      reg_write(IWAC_CTRL_OFS, 8'h80);
      m.start_cond();
      scl_rises = 0;
      m.let_go();
      mst_wait(9);
      reg_write(IWAC_CTRL_OFS, 8'hA0);
      mst_wait(17);
      pop(8'hFF);
      reg_write(IWAC_CTRL_OFS, 8'h00);
      master_mode <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(serial_clock_line_oe === 1'b0 && serial_data_line_oe === 1'b0,
          "master kept the bus after disable");
   endtask

   initial begin
      sys_clk     = 1'b0;
      rst         = 1'b1;
      clk_en      = 1'b1;
      master_mode = 1'b0;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      reg_addr    = '0;
      reg_wdata   = '0;
      rx_ready    = 1'b0;
      err_total   = 0;
      tests_run   = 0;
      intr_cnt    = 0;
      drive_cnt   = 0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_off();
      t_sel0();
      t_sel1();
      t_ext();
      t_mst();
      wrap_up();
   end
endmodule
`default_nettype wire
